//--- pkg/ssd_pkg.sv
// constants and types shared by the step sequencer files
package ssd_pkg;
  localparam int NUM_STEPS = 16;
  localparam int NUM_OUTS = 16;
  localparam int NUM_CTRS = 128;
  // byte offsets on the apb bus
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_TIMEBASE = 12'h004;
  localparam logic [11:0] OFF_CTR_BASE = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00c;
  localparam logic [11:0] OFF_LAST = 12'h010;
  localparam logic [11:0] OFF_COUNT = 12'h014;
  localparam logic [11:0] OFF_TIMER = 12'h018;
  localparam logic [11:0] OFF_PRESET = 12'h01c;
  localparam logic [11:0] OFF_CURRENT = 12'h020;
  localparam logic [11:0] OFF_STEP_CFG = 12'h040;
  localparam logic [11:0] OFF_CTR_WIN = 12'h200;
  // field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_RETAIN_BIT = 1;
  localparam int CFG_CPS_LSB = 16;
  localparam int CFG_TIME_BIT = 30;
  localparam int CFG_EVENT_BIT = 31;
  localparam int WIN_FLAG_BIT = 16;
  // reset values and limits
  localparam logic CTRL_RUN_RST = 1'b0;
  localparam logic CTRL_RETAIN_RST = 1'b1;
  localparam logic [13:0] TIMEBASE_RST = 14'h0001;
  localparam logic [13:0] MAX_TB_CPS = 14'h270f;
  localparam logic [6:0] CTR_BASE_RST = 7'h00;
  localparam logic [6:0] CTR_BASE_MAX = 7'h7c;
  localparam logic [4:0] STEP_MIN = 5'h01;
  localparam logic [4:0] STEP_MAX = 5'h10;
  localparam logic [4:0] PRESET_RST = 5'h01;
  localparam logic [4:0] LAST_RST = 5'h10;
  // timing: base tick of 0.01 s and scan period
  localparam int CLK_NS = 20;
  localparam int BASE_TICK_NS = 10000000;
  localparam int BASE_TICK_CYC = BASE_TICK_NS / CLK_NS;
  localparam int SCAN_NS = 1000000;
  localparam int SCAN_CYC = SCAN_NS / CLK_NS;
  typedef enum logic {
    SSD_RUNNING = 1'b0,
    SSD_COMPLETE = 1'b1
  } ssd_state_t;
endpackage : ssd_pkg

//--- pkg/ssd_tick_if.sv
// scan strobe and elapsed hundredths from the tick generator
`timescale 1ns/1ps
`default_nettype none
interface ssd_tick_if;
  logic scan;
  logic [15:0] elapsed;
  modport src (output scan, output elapsed);
  modport snk (input scan, input elapsed);
endinterface : ssd_tick_if
`default_nettype wire

//--- src/ssd_sync.sv
// two-flop synchroniser for a group of level inputs
`timescale 1ns/1ps
`default_nettype none
module ssd_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : ssd_sync
`default_nettype wire

//--- src/ssd_scan_tick.sv
// scan strobe plus count of 0.01 s ticks since the last scan
`timescale 1ns/1ps
`default_nettype none
module ssd_scan_tick #(
  parameter int TICK_CYCLES = ssd_pkg::BASE_TICK_CYC,
  parameter int SCAN_CYCLES = ssd_pkg::SCAN_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  ssd_tick_if.src tk
);
  import ssd_pkg::*;
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int SW = $clog2(SCAN_CYCLES + 1);
  logic [TW-1:0] tick_cnt_r;
  logic [SW-1:0] scan_cnt_r;
  logic [15:0] hund_r;
  wire base_tick = tick_cnt_r == TW'(TICK_CYCLES - 1);
  wire scan_now = scan_cnt_r == SW'(SCAN_CYCLES - 1);
  // saturate so a very slow scan never wraps the elapsed figure
  wire [15:0] hund_sum = (hund_r == 16'hffff) ? hund_r : hund_r + {15'h0000, base_tick};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= '0;
      scan_cnt_r <= '0;
      hund_r <= 16'h0000;
      tk.scan <= 1'b0;
      tk.elapsed <= 16'h0000;
    end else begin
      tick_cnt_r <= base_tick ? '0 : tick_cnt_r + TW'(1);
      scan_cnt_r <= scan_now ? '0 : scan_cnt_r + SW'(1);
      hund_r <= scan_now ? 16'h0000 : hund_sum;
      tk.scan <= scan_now;
      tk.elapsed <= scan_now ? hund_sum : tk.elapsed;
    end
  end
endmodule : ssd_scan_tick
`default_nettype wire

//--- src/ssd_sequencer.sv
// sixteen-step event sequencer with apb registers
`timescale 1ns/1ps
`default_nettype none
module ssd_sequencer #(
  parameter int TICK_CYCLES = ssd_pkg::BASE_TICK_CYC,
  parameter int SCAN_CYCLES = ssd_pkg::SCAN_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic seq_start,
  input wire logic seq_jog,
  input wire logic seq_reset,
  input wire logic [ssd_pkg::NUM_STEPS-1:0] step_event,
  output logic [ssd_pkg::NUM_OUTS-1:0] pattern_out,
  output logic counter_flag
);
  import ssd_pkg::*;

  logic [31:0] step_cfg_r [NUM_STEPS];
  logic run_r, run_d_r, retain_r, jog_q_r, jog_pend_r;
  logic [13:0] timebase_r;
  logic [6:0] ctr_base_r;
  logic [4:0] last_r, preset_r, cur_r;
  logic [15:0] count_r, timer_r;
  ssd_state_t state_r;
  logic [4:0] cur_nxt;
  logic [15:0] count_nxt, timer_nxt;
  ssd_state_t state_nxt;
  logic jog_take;
  logic [31:0] rd_data;
  logic start_s, jog_s, rst_s;
  logic [NUM_STEPS-1:0] ev_s;

  ssd_tick_if tk ();

  ssd_scan_tick #(
    .TICK_CYCLES(TICK_CYCLES),
    .SCAN_CYCLES(SCAN_CYCLES)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tk(tk)
  );

  // control program levels come from another clock domain
  ssd_sync #(
    .W(NUM_STEPS + 3)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({seq_start, seq_jog, seq_reset, step_event}),
    .q({start_s, jog_s, rst_s, ev_s})
  );

  // apb decode
  wire access = psel & penable & pready;
  wire wr_fire = access & pwrite;
  wire hit_ctrl = paddr == OFF_CTRL;
  wire hit_tb = paddr == OFF_TIMEBASE;
  wire hit_base = paddr == OFF_CTR_BASE;
  wire hit_stat = paddr == OFF_STATUS;
  wire hit_last = paddr == OFF_LAST;
  wire hit_count = paddr == OFF_COUNT;
  wire hit_timer = paddr == OFF_TIMER;
  wire hit_preset = paddr == OFF_PRESET;
  wire hit_cur = paddr == OFF_CURRENT;
  wire hit_cfg = (paddr[11:6] == OFF_STEP_CFG[11:6]) & (paddr[1:0] == 2'b00);
  wire hit_win = (paddr[11:9] == OFF_CTR_WIN[11:9]) & (paddr[1:0] == 2'b00);
  wire mapped = hit_ctrl | hit_tb | hit_base | hit_stat | hit_last | hit_count |
                hit_timer | hit_preset | hit_cur | hit_cfg | hit_win;
  wire [3:0] cfg_idx = paddr[5:2];
  wire [6:0] win_rel = paddr[8:2] - ctr_base_r;
  wire [13:0] wr_tb = pwdata[13:0];
  wire [4:0] wr_step = pwdata[4:0];
  wire step_ok = (pwdata[31:5] == 27'h0) & (wr_step >= STEP_MIN) & (wr_step <= STEP_MAX);
  wire tb_ok = (pwdata[31:14] == 18'h0) & (wr_tb != 14'h0000) & (wr_tb <= MAX_TB_CPS);
  wire base_ok = (pwdata[31:7] == 25'h0) & (pwdata[6:0] <= CTR_BASE_MAX);
  wire cfg_ok = pwdata[CFG_CPS_LSB +: 14] <= MAX_TB_CPS;
  wire wr_preset = wr_fire & hit_preset & step_ok;
  wire wr_cfg = wr_fire & hit_cfg & cfg_ok;
  wire wr_ctrl = wr_fire & hit_ctrl;

  // counter words as seen by the control program
  wire [15:0] ctr_word [4];
  assign ctr_word[0] = count_r;
  assign ctr_word[1] = timer_r;
  assign ctr_word[2] = {11'h000, preset_r};
  assign ctr_word[3] = {11'h000, cur_r};
  wire [31:0] win_data = (win_rel > 7'h03) ? 32'h0 :
                         {15'h0, (win_rel == 7'h00) & counter_flag, ctr_word[win_rel[1:0]]};

  always_comb begin
    rd_data = 32'h0;
    if (hit_ctrl) rd_data = {30'h0, retain_r, run_r};
    if (hit_tb) rd_data = {18'h0, timebase_r};
    if (hit_base) rd_data = {25'h0, ctr_base_r};
    if (hit_stat) rd_data = {30'h0, jog_pend_r, counter_flag};
    if (hit_last) rd_data = {27'h0, last_r};
    if (hit_count) rd_data = {16'h0, count_r};
    if (hit_timer) rd_data = {16'h0, timer_r};
    if (hit_preset) rd_data = {27'h0, preset_r};
    if (hit_cur) rd_data = {27'h0, cur_r};
    if (hit_cfg) rd_data = step_cfg_r[cfg_idx];
    if (hit_win) rd_data = win_data;
  end

  // current step fields
  wire [3:0] cur_idx = 4'(cur_r - 5'h01);
  wire [31:0] cur_cfg = step_cfg_r[cur_idx];
  wire ev_en = cur_cfg[CFG_EVENT_BIT];
  wire tm_en = cur_cfg[CFG_TIME_BIT];
  wire [15:0] cps = {2'b00, cur_cfg[CFG_CPS_LSB +: 14]};
  wire ev_cur = ev_s[cur_idx];
  wire run_rise = run_r & ~run_d_r;
  wire jog_rise = jog_s & ~jog_q_r;
  wire running = state_r == SSD_RUNNING;
  wire eval_ok = tk.scan & run_r & running & ~rst_s & ~run_rise;
  wire at_last = (cur_r >= last_r) | (cur_r == STEP_MAX);
  // timer sum is one bit wider and cannot wrap; timebase is at most 9999 so this never clips a compare
  wire [16:0] tv_sum = {1'b0, timer_r} + {1'b0, tk.elapsed};
  wire tb_done = tv_sum >= {3'b000, timebase_r};
  wire [15:0] cnt_inc = count_r + 16'h0001;
  wire gate_ok = ~ev_en | ev_cur;
  wire time_adv = tm_en & gate_ok & tb_done & (cnt_inc >= cps);
  wire event_adv = ev_en & ~tm_en & ev_cur;
  wire idle_adv = ~ev_en & ~tm_en;
  wire do_eval = eval_ok & ~jog_pend_r & start_s;
  wire advance = (eval_ok & jog_pend_r) | (do_eval & (time_adv | event_adv | idle_adv));

  always_comb begin
    cur_nxt = cur_r;
    count_nxt = count_r;
    timer_nxt = timer_r;
    state_nxt = state_r;
    jog_take = 1'b0;
    if (run_r & rst_s) begin
      cur_nxt = preset_r;
      count_nxt = 16'h0000;
      timer_nxt = 16'h0000;
      state_nxt = SSD_RUNNING;
    end else if (run_rise) begin
      state_nxt = SSD_RUNNING;
      if (!retain_r || !running) begin
        cur_nxt = preset_r;
        count_nxt = 16'h0000;
        timer_nxt = 16'h0000;
      end
    end else if (advance) begin
      jog_take = jog_pend_r;
      count_nxt = 16'h0000;
      timer_nxt = 16'h0000;
      if (at_last) begin
        state_nxt = SSD_COMPLETE;
      end else begin
        cur_nxt = cur_r + 5'h01;
      end
    end else if (do_eval & tm_en & gate_ok) begin
      if (tb_done) begin
        count_nxt = cnt_inc;
        timer_nxt = 16'h0000;
      end else begin
        timer_nxt = tv_sum[15:0];
      end
    end
  end

  // apb answer registers; pready rises one cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~pready;
      prdata <= (psel & ~pready & ~pwrite) ? rd_data : prdata;
      pslverr <= psel & ~pready & ~mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= CTRL_RUN_RST;
      retain_r <= CTRL_RETAIN_RST;
      timebase_r <= TIMEBASE_RST;
      ctr_base_r <= CTR_BASE_RST;
      last_r <= LAST_RST;
      preset_r <= PRESET_RST;
    end else begin
      if (wr_ctrl) begin
        run_r <= pwdata[CTRL_RUN_BIT];
        retain_r <= pwdata[CTRL_RETAIN_BIT];
      end
      if (wr_fire & hit_tb & tb_ok) timebase_r <= wr_tb;
      if (wr_fire & hit_base & base_ok) ctr_base_r <= pwdata[6:0];
      if (wr_fire & hit_last & step_ok) last_r <= wr_step;
      if (wr_preset) preset_r <= wr_step;
    end
  end

  // step table: pattern, count target, time and event enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_STEPS; i++) begin
        step_cfg_r[i] <= 32'h0;
      end
    end else if (wr_cfg) begin
      step_cfg_r[cfg_idx] <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_d_r <= 1'b0;
      jog_q_r <= 1'b0;
      jog_pend_r <= 1'b0;
      cur_r <= PRESET_RST;
      count_r <= 16'h0000;
      timer_r <= 16'h0000;
      state_r <= SSD_RUNNING;
      pattern_out <= '0;
      counter_flag <= 1'b0;
    end else begin
      run_d_r <= run_r;
      jog_q_r <= jog_s;
      // a new jog edge wins over the one being consumed
      jog_pend_r <= (jog_pend_r & ~jog_take & ~rst_s & running) |
                    (jog_rise & run_r & ~rst_s & running);
      cur_r <= cur_nxt;
      count_r <= count_nxt;
      timer_r <= timer_nxt;
      state_r <= state_nxt;
      // pattern outputs idle outside run mode, live in it
      pattern_out <= run_r ? step_cfg_r[4'(cur_nxt - 5'h01)][15:0] : '0;
      counter_flag <= state_nxt == SSD_COMPLETE;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_reset_preset: assert property (run_r && rst_s |=> cur_r == $past(preset_r) && count_r == 16'h0 && timer_r == 16'h0 && !counter_flag)
    else $error("reset did not hold the preset step");
  chk_complete_ignores: assert property (!running && !rst_s && !run_rise |=> cur_r == $past(cur_r) && counter_flag)
    else $error("complete state moved without reset");
  chk_flag_on_last: assert property ($rose(counter_flag) |-> $past(cur_r) >= $past(last_r) || $past(cur_r) == STEP_MAX)
    else $error("flag set before the last step");
  chk_pattern_follows: assert property (run_r && $past(run_r) && !$past(wr_cfg) |-> pattern_out == step_cfg_r[cur_idx][15:0])
    else $error("outputs do not follow the current step");
  chk_stop_freezes: assert property (run_r && !start_s && !rst_s && !jog_pend_r && !run_rise |=> cur_r == $past(cur_r) && timer_r == $past(timer_r))
    else $error("sequencer moved with start low");
  chk_jog_step: assert property (eval_ok && jog_pend_r && !at_last |=> cur_r == 5'($past(cur_r) + 5'h01) && timer_r == 16'h0)
    else $error("jog did not advance one step");
  chk_event_gate: assert property (do_eval && ev_en && tm_en && !ev_cur |=> timer_r == $past(timer_r) && cur_r == $past(cur_r))
    else $error("timer ran with event false");
  chk_target_advance: assert property (do_eval && time_adv |=> cur_r != $past(cur_r) || counter_flag)
    else $error("count target reached without transition");
  chk_preset_write: assert property (preset_r != $past(preset_r) |-> $past(wr_preset))
    else $error("preset changed without a write");
  chk_run_entry: assert property (run_rise && !rst_s && !retain_r |=> cur_r == $past(preset_r) && count_r == 16'h0 ##1 !counter_flag)
    else $error("run entry did not load the preset");
  chk_apb_answer: assert property (psel && !penable && !pready |=> pready)
    else $error("apb answer late");

  cov_complete: cover property (running ##1 !running);
  cov_jog: cover property (eval_ok && jog_pend_r && !start_s);
  cov_reset_out: cover property (!running && rst_s ##1 running);
  cov_event_step: cover property (do_eval && event_adv);
endmodule : ssd_sequencer
`default_nettype wire

//--- test/ssd_ctl_model.sv
// control program model driving start, jog, reset and step events
`timescale 1ns/1ps
`default_nettype none
module ssd_ctl_model (
  input wire logic pclk,
  output logic seq_start,
  output logic seq_jog,
  output logic seq_reset,
  output logic [15:0] step_event
);
  initial begin
    seq_start = 1'b0;
    seq_jog = 1'b0;
    seq_reset = 1'b0;
    step_event = 16'h0000;
  end
  task automatic set(input logic s, input logic r, input logic [15:0] ev);
    @(posedge pclk);
    seq_start <= s;
    seq_reset <= r;
    step_event <= ev;
  endtask : set
  // each level is held for whole scans so the synced edge is never missed
  task automatic jog(input int hold);
    @(posedge pclk);
    seq_jog <= 1'b1;
    repeat (hold) @(posedge pclk);
    seq_jog <= 1'b0;
    repeat (hold) @(posedge pclk);
  endtask : jog
endmodule : ssd_ctl_model
`default_nettype wire

//--- test/ssd_sequencer_tb.sv
// self-checking bench for the step sequencer
`timescale 1ns/1ps
`default_nettype none
module ssd_sequencer_tb;
  import ssd_pkg::*;
  localparam logic [15:0] P1 = 16'ha5c3;
  localparam logic [15:0] P2 = 16'h3c5a;
  localparam logic [15:0] P3 = 16'h0ff0;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic seq_start, seq_jog, seq_reset, counter_flag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] step_event, pattern_out;
  int num_errors = 0;
  int n_tests = 0;
  int c;
  // short tick and scan so a full cycle of steps fits in a few hundred clocks
  ssd_sequencer #(.TICK_CYCLES(4), .SCAN_CYCLES(8)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .seq_start(seq_start),
    .seq_jog(seq_jog), .seq_reset(seq_reset), .step_event(step_event),
    .pattern_out(pattern_out), .counter_flag(counter_flag));
  ssd_ctl_model i_ctl (.pclk(pclk), .seq_start(seq_start), .seq_jog(seq_jog),
    .seq_reset(seq_reset), .step_event(step_event));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 50) begin
      num_errors++;
      close_out();
    end
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(n, rd, e);
  endtask : rchk
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  // registered outputs read in the active region hold the value of the last edge
  task automatic wait_out(input logic f, input logic [15:0] p);
    c = 0;
    while ((counter_flag !== f || pattern_out !== p) && c < 2000) begin
      @(posedge pclk);
      c++;
    end
    check("flag", {31'h0, counter_flag}, {31'h0, f});
    check("pattern", {16'h0, pattern_out}, {16'h0, p});
    if (c >= 2000) close_out();
  endtask : wait_out
  task automatic t_regs();
    rchk("ctrl", OFF_CTRL, {30'h0, CTRL_RETAIN_RST, CTRL_RUN_RST});
    rchk("preset", OFF_PRESET, 32'h1);
    rchk("current", OFF_CURRENT, 32'h1);
    rchk("count", OFF_COUNT, 32'h0);
    rchk("timer", OFF_TIMER, 32'h0);
    wr(OFF_CURRENT, 32'h5);
    rchk("current ro", OFF_CURRENT, 32'h1);
    wr(OFF_PRESET, 32'h0);
    wr(OFF_PRESET, 32'h11);
    rchk("preset range", OFF_PRESET, 32'h1);
    apb(1'b0, 12'h100, 32'h0);
    check("slverr", {31'h0, er}, 32'h1);
  endtask : t_regs
  task automatic t_timed();
    wr(OFF_TIMEBASE, 32'h2);
    wr(OFF_STEP_CFG, {2'b01, 14'h3, P1});
    wr(OFF_STEP_CFG + 12'h004, {2'b01, 14'h3, P2});
    wr(OFF_LAST, 32'h2);
    wr(OFF_CTRL, 32'h3);
    wait_out(1'b0, P1);
    cyc(32);
    check("frozen", {16'h0, pattern_out}, {16'h0, P1});
    rchk("frozen count", OFF_COUNT, 32'h0);
    i_ctl.set(1'b1, 1'b0, 16'h0);
    wait_out(1'b0, P2);
    check("dwell", {31'h0, c >= 16}, 32'h1);
    wait_out(1'b1, P2);
    i_ctl.jog(16);
    cyc(32);
    check("done jog", {15'h0, counter_flag, pattern_out}, {15'h1, P2});
    i_ctl.set(1'b1, 1'b1, 16'h0);
    wait_out(1'b0, P1);
    cyc(40);
    check("held", {16'h0, pattern_out}, {16'h0, P1});
    rchk("held count", OFF_COUNT, 32'h0);
  endtask : t_timed
  task automatic t_event();
    wr(OFF_STEP_CFG, {2'b11, 14'h2, P1});
    wr(OFF_STEP_CFG + 12'h004, {2'b10, 14'h0, P2});
    wr(OFF_STEP_CFG + 12'h008, {2'b01, 14'h1, P3});
    wr(OFF_LAST, 32'h3);
    i_ctl.set(1'b1, 1'b0, 16'h0);
    cyc(48);
    check("no event", {16'h0, pattern_out}, {16'h0, P1});
    rchk("no event timer", OFF_TIMER, 32'h0);
    i_ctl.set(1'b1, 1'b0, 16'h0001);
    wait_out(1'b0, P2);
    cyc(40);
    check("event only", {16'h0, pattern_out}, {16'h0, P2});
    i_ctl.set(1'b1, 1'b0, 16'h0002);
    wait_out(1'b0, P3);
    wait_out(1'b1, P3);
  endtask : t_event
  task automatic t_jog();
    i_ctl.set(1'b0, 1'b1, 16'h0);
    wait_out(1'b0, P1);
    i_ctl.set(1'b0, 1'b0, 16'h0);
    i_ctl.jog(16);
    i_ctl.jog(16);
    wait_out(1'b0, P3);
    rchk("jog timer", OFF_TIMER, 32'h0);
    i_ctl.jog(16);
    wait_out(1'b1, P3);
  endtask : t_jog
  task automatic t_window();
    wr(OFF_CTR_BASE, 32'h4);
    rchk("win preset", OFF_CTR_WIN + 12'h018, 32'h1);
    wr(OFF_PRESET, 32'h2);
    rchk("win preset wr", OFF_CTR_WIN + 12'h018, 32'h2);
    rchk("win current", OFF_CTR_WIN + 12'h01c, 32'h3);
    rchk("win other", OFF_CTR_WIN + 12'h00c, 32'h0);
    apb(1'b0, OFF_CTR_WIN + 12'h010, 32'h0);
    check("win flag", {31'h0, rd[WIN_FLAG_BIT]}, 32'h1);
  endtask : t_window
  task automatic t_runentry();
    // drop the step 2 event so the entry step cannot move before it is read
    i_ctl.set(1'b1, 1'b0, 16'h0);
    wr(OFF_CTRL, 32'h0);
    cyc(4);
    check("run off", {16'h0, pattern_out}, 32'h0);
    wr(OFF_CTRL, 32'h1);
    wait_out(1'b0, P2);
    rchk("entry current", OFF_CURRENT, 32'h2);
    rchk("entry count", OFF_COUNT, 32'h0);
  endtask : t_runentry
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_timed();
    t_event();
    t_jog();
    t_window();
    t_runentry();
    close_out();
  end
endmodule : ssd_sequencer_tb
`default_nettype wire
